// ---- design/srw_supervisor.sv ----
// supervisor: supply, push-button and watchdog reset sources
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor #(
    parameter logic [srw_pkg::CNT_W-1:0] RST_HOLD_CYC = srw_pkg::RST_HOLD_CYC,
    parameter logic [srw_pkg::CNT_W-1:0] DEBOUNCE_CYC = srw_pkg::DEBOUNCE_CYC,
    parameter logic [srw_pkg::CNT_W-1:0] WD_SHORT_CYC = srw_pkg::WD_SHORT_CYC,
    parameter logic [srw_pkg::CNT_W-1:0] WD_MID_CYC = srw_pkg::WD_MID_CYC,
    parameter logic [srw_pkg::CNT_W-1:0] WD_LONG_CYC = srw_pkg::WD_LONG_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic supply_fail,
    input wire logic trip_tolerance_select,
    input wire logic manual_reset_n,
    input wire logic [1:0] watchdog_period_select,
    input wire logic watchdog_strobe_n,
    output logic tol_select_20pct,
    output logic reset_hi,
    output logic reset_n
);

    // ========================================
    // helpers
    function automatic logic [srw_pkg::CNT_W-1:0] inc(
        input logic [srw_pkg::CNT_W-1:0] v
    );
        inc = v + srw_pkg::CNT_ONE;
    endfunction

    function automatic logic [srw_pkg::CNT_W-1:0] wd_limit(
        input logic [1:0] sel
    );
        case (sel)
            srw_pkg::WD_SEL_LOW: begin
                wd_limit = WD_SHORT_CYC;
            end
            srw_pkg::WD_SEL_FLOAT: begin
                wd_limit = WD_MID_CYC;
            end
            default: begin
                wd_limit = WD_LONG_CYC;
            end
        endcase
    endfunction

    // ========================================
    // declarations
    logic strobe_seen;
    logic pb_sample;
    logic next_pb_sample;
    logic pb_low;
    logic next_pb_low;
    logic [srw_pkg::CNT_W-1:0] deb_cnt;
    logic [srw_pkg::CNT_W-1:0] next_deb_cnt;
    logic [srw_pkg::CNT_W-1:0] wd_cnt;
    logic [srw_pkg::CNT_W-1:0] next_wd_cnt;
    logic [srw_pkg::CNT_W-1:0] wd_end;
    logic wd_expire;
    srw_pkg::srw_state_t state;
    srw_pkg::srw_state_t next_state;
    logic [srw_pkg::CNT_W-1:0] hold_cnt;
    logic [srw_pkg::CNT_W-1:0] next_hold_cnt;
    logic src_level;
    logic next_reset;
    logic next_tol;

    // ========================================
    // strobe edge capture
    srw_strobe_catch u_catch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .watchdog_strobe_n(watchdog_strobe_n),
        .strobe_seen(strobe_seen)
    );

    // ========================================
    // tolerance select to comparator
    always_comb begin
        next_tol = trip_tolerance_select;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tol_select_20pct <= srw_pkg::TOL_RST;
        end else begin
            tol_select_20pct <= next_tol;
        end
    end

    // ========================================
    // push-button debounce
    always_comb begin
        next_pb_sample = manual_reset_n;
        next_pb_low = pb_low;
        next_deb_cnt = srw_pkg::CNT_ZERO;
        if (pb_sample != pb_low) begin
            next_deb_cnt = srw_pkg::CNT_ZERO;
        end else if (deb_cnt == DEBOUNCE_CYC - srw_pkg::CNT_ONE) begin
            next_pb_low = ~pb_low;
            next_deb_cnt = srw_pkg::CNT_ZERO;
        end else begin
            next_deb_cnt = inc(deb_cnt);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pb_sample <= srw_pkg::SAMPLE_RST;
            pb_low <= srw_pkg::PB_RST;
            deb_cnt <= srw_pkg::CNT_ZERO;
        end else begin
            pb_sample <= next_pb_sample;
            pb_low <= next_pb_low;
            deb_cnt <= next_deb_cnt;
        end
    end

    // ========================================
    // watchdog, counts whenever reset is released
    always_comb begin
        wd_end = wd_limit(watchdog_period_select);
        wd_expire = 1'b0;
        next_wd_cnt = srw_pkg::CNT_ZERO;
        if (state != srw_pkg::SRW_RUN || src_level) begin
            next_wd_cnt = srw_pkg::CNT_ZERO;
        end else if (strobe_seen) begin
            next_wd_cnt = srw_pkg::CNT_ZERO;
        end else if (wd_cnt >= wd_end - srw_pkg::CNT_ONE) begin
            wd_expire = 1'b1;
        end else begin
            next_wd_cnt = inc(wd_cnt);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_cnt <= srw_pkg::CNT_ZERO;
        end else begin
            wd_cnt <= next_wd_cnt;
        end
    end

    // ========================================
    // reset sequencer
    always_comb begin
        src_level = supply_fail | pb_low;
        next_state = state;
        next_hold_cnt = srw_pkg::CNT_ZERO;
        case (state)
            srw_pkg::SRW_ACTIVE: begin
                if (!src_level) begin
                    next_state = srw_pkg::SRW_HOLD;
                end
            end
            srw_pkg::SRW_HOLD: begin
                if (src_level) begin
                    next_state = srw_pkg::SRW_ACTIVE;
                end else if (hold_cnt ==
                             RST_HOLD_CYC - srw_pkg::CNT_ONE) begin
                    next_state = srw_pkg::SRW_RUN;
                end else begin
                    next_hold_cnt = inc(hold_cnt);
                end
            end
            srw_pkg::SRW_RUN: begin
                if (src_level || wd_expire) begin
                    next_state = srw_pkg::SRW_ACTIVE;
                end
            end
            default: begin
                next_state = srw_pkg::SRW_ACTIVE;
            end
        endcase
        next_reset = (next_state != srw_pkg::SRW_RUN);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= srw_pkg::SRW_ACTIVE;
            hold_cnt <= srw_pkg::CNT_ZERO;
            reset_hi <= srw_pkg::RESET_ON;
            reset_n <= ~srw_pkg::RESET_ON;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            reset_hi <= next_reset;
            reset_n <= ~next_reset;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_reset_complement: assert property (
        reset_hi == ~reset_n
    ) else $error("reset outputs not complementary");

    a_supply_fail_reset: assert property (
        supply_fail |=> reset_hi && !reset_n
    ) else $error("supply fail did not assert reset");

    a_hold_min_time: assert property (
        $fell(reset_hi) |->
            $past(state) == srw_pkg::SRW_HOLD &&
            $past(hold_cnt) == RST_HOLD_CYC - srw_pkg::CNT_ONE
    ) else $error("reset released before full hold");

    a_tol_passed: assert property (
        $changed(trip_tolerance_select) |=>
            tol_select_20pct == $past(trip_tolerance_select)
    ) else $error("tolerance select not passed on");

    a_pb_holds_reset: assert property (
        pb_low |=> reset_hi ##1 reset_hi
    ) else $error("manual reset did not hold reset");

    a_pb_debounce_time: assert property (
        $rose(pb_low) |->
            $past(deb_cnt) == DEBOUNCE_CYC - srw_pkg::CNT_ONE &&
            !$past(pb_sample)
    ) else $error("manual reset recognised at wrong time");

    a_wd_limit_select: assert property (
        wd_expire |->
            wd_cnt >= wd_limit(watchdog_period_select) - srw_pkg::CNT_ONE
    ) else $error("watchdog expired early");

    a_wd_timeout_reset: assert property (
        wd_expire |=> reset_hi ##1 (state == srw_pkg::SRW_HOLD ||
                                    state == srw_pkg::SRW_ACTIVE)
    ) else $error("watchdog expiry did not reset");

    a_wd_edge_restart: assert property (
        state == srw_pkg::SRW_RUN && strobe_seen |=> wd_cnt == '0
    ) else $error("strobe edge did not restart watchdog");

    a_wd_always_counts: assert property (
        state == srw_pkg::SRW_RUN && !strobe_seen && !wd_expire &&
            !src_level |=>
            wd_cnt == $past(wd_cnt) + srw_pkg::CNT_ONE
    ) else $error("watchdog stopped counting");

    a_wd_idle_clear: assert property (
        reset_hi |-> wd_cnt == '0
    ) else $error("watchdog counted during reset");

endmodule
`default_nettype wire

// ---- shared/srw_pkg.sv ----
// shared constants and types for the supervisor reset watchdog
// Function
// - assert both resets at power-up and while supply is out of tolerance
// - active-high and active-low resets are always exact complements
// - hold resets at least 250ms after supply returns in tolerance
// - tolerance select low picks 10%, high picks 20%, passed to comparator
// - manual reset held low asserts resets, held 250ms after release
// - debounce manual reset; any low pulse over 20ms is recognised
// - watchdog timeout 150ms low, 610ms floating, 1200ms high
// - no strobe falling edge before timeout generates a reset
// - only strobe falling edges restart the watchdog; levels never do
// - the watchdog cannot be disabled and counts whenever reset is released
// - strobe pulses down to 20ns are caught without the slow clock
package srw_pkg;

    // ========================================
    // timebase
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int CNT_W = 24;

    // ========================================
    // times in ms and derived cycle counts
    localparam int RST_HOLD_MS = 250;
    localparam int DEBOUNCE_MS = 20;
    localparam int WD_SHORT_MS = 150;
    localparam int WD_MID_MS = 610;
    localparam int WD_LONG_MS = 1200;
    localparam logic [CNT_W-1:0] RST_HOLD_CYC =
        CNT_W'(RST_HOLD_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] DEBOUNCE_CYC =
        CNT_W'(DEBOUNCE_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] WD_SHORT_CYC =
        CNT_W'(WD_SHORT_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] WD_MID_CYC =
        CNT_W'(WD_MID_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] WD_LONG_CYC =
        CNT_W'(WD_LONG_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    // ========================================
    // watchdog period strap codes
    localparam logic [1:0] WD_SEL_LOW = 2'h0;
    localparam logic [1:0] WD_SEL_FLOAT = 2'h1;
    localparam logic [1:0] WD_SEL_HIGH = 2'h2;

    // ========================================
    // reset values
    localparam logic RESET_ON = 1'b1;
    localparam logic TOL_RST = 1'b0;
    localparam logic PB_RST = 1'b0;
    localparam logic SAMPLE_RST = 1'b1;
    localparam logic TOGGLE_RST = 1'b0;

    // ========================================
    // reset sequencer states
    typedef enum logic [2:0] {
        SRW_ACTIVE = 3'b001,
        SRW_HOLD = 3'b010,
        SRW_RUN = 3'b100
    } srw_state_t;

endpackage

// ---- design/srw_strobe_catch.sv ----
// strobe falling-edge catcher with toggle crossing into the timebase
`timescale 1ns/1ps
`default_nettype none
module srw_strobe_catch (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic watchdog_strobe_n,
    output logic strobe_seen
);

    logic toggle;
    logic next_toggle;
    logic sync1;
    logic sync2;
    logic sync3;

    // ========================================
    // edge capture, clocked by the strobe itself
    always_comb begin
        next_toggle = ~toggle;
    end

    always_ff @(negedge watchdog_strobe_n or negedge rst_b) begin
        if (!rst_b) begin
            toggle <= srw_pkg::TOGGLE_RST;
        end else begin
            toggle <= next_toggle;
        end
    end

    // ========================================
    // toggle synchroniser and edge pulse
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= srw_pkg::TOGGLE_RST;
            sync2 <= srw_pkg::TOGGLE_RST;
            sync3 <= srw_pkg::TOGGLE_RST;
        end else begin
            sync1 <= toggle;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_comb begin
        strobe_seen = sync2 ^ sync3;
    end

endmodule
`default_nettype wire

// ---- dv/srw_cpu_model.sv ----
// behavioural model of the monitored processor strobing the watchdog
`timescale 1ns/1ps
`default_nettype none
module srw_cpu_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic strobe_en,
    input wire logic idle_level,
    input wire logic [7:0] interval,
    output logic watchdog_strobe_n
);
    logic [7:0] cnt;
    logic was_en;

    initial begin
        watchdog_strobe_n = 1'b1;
        cnt = 8'h00;
        was_en = 1'b0;
    end

    // 20ns low pulse placed between clock edges
    task automatic pulse(input logic after);
        #10 watchdog_strobe_n = 1'b0;
        #20 watchdog_strobe_n = after;
    endtask

    // ========================================
    // strobe generation
    always @(negedge core_clk) begin
        if (!strobe_en) begin
            // last strobe, then a static level of either polarity
            if (was_en) pulse(idle_level);
            was_en = 1'b0;
            cnt = 8'h00;
        end else begin
            if (!was_en) watchdog_strobe_n = 1'b1;
            was_en = 1'b1;
            cnt = (reset_n === 1'b1) ? cnt + 8'h01 : 8'h00;
            if (cnt >= interval) begin
                cnt = 8'h00;
                pulse(1'b1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_srw_supervisor.sv ----
// self-checking bench for the supervisor reset watchdog
`timescale 1ns/1ps
`default_nettype none
module test_srw_supervisor;
    // ========================================
    // shortened counts
    localparam logic [srw_pkg::CNT_W-1:0] HOLD = 24'h000014;
    localparam logic [srw_pkg::CNT_W-1:0] DEB = 24'h000005;
    localparam logic [srw_pkg::CNT_W-1:0] WDS = 24'h000028;
    localparam logic [srw_pkg::CNT_W-1:0] WDM = 24'h00003c;
    localparam logic [srw_pkg::CNT_W-1:0] WDL = 24'h000050;

    logic core_clk, rst_b, supply_fail, trip_tolerance_select;
    logic manual_reset_n, watchdog_strobe_n;
    logic [1:0] watchdog_period_select;
    logic tol_select_20pct, reset_hi, reset_n, strobe_en, idle_level;
    logic [7:0] interval;
    int errors, total_checks, seed, lim, w;

    srw_supervisor #(.RST_HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB),
        .WD_SHORT_CYC(WDS), .WD_MID_CYC(WDM), .WD_LONG_CYC(WDL)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .supply_fail(supply_fail),
        .trip_tolerance_select(trip_tolerance_select),
        .manual_reset_n(manual_reset_n),
        .watchdog_period_select(watchdog_period_select),
        .watchdog_strobe_n(watchdog_strobe_n),
        .tol_select_20pct(tol_select_20pct), .reset_hi(reset_hi),
        .reset_n(reset_n));

    srw_cpu_model cpu (.core_clk(core_clk), .reset_n(reset_n),
        .strobe_en(strobe_en), .idle_level(idle_level),
        .interval(interval), .watchdog_strobe_n(watchdog_strobe_n));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ========================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi,
                           input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR %s expected %0d to %0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    // cycles until reset_hi reaches v, bounded
    task automatic wait_lvl(input string what, input logic v, input int lo,
                            input int hi);
        int n;
        n = 0;
        while (reset_hi !== v && n <= hi) begin
            cyc(1);
            n++;
        end
        chk_rng(what, lo, hi, n);
        if (n > hi) print_verdict;
    endtask

    task automatic quiet(input string what, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            cyc(1);
            if (reset_hi !== 1'b0) bad = 1'b1;
        end
        chk(what, 0, bad);
    endtask

    function automatic int wd_limit(input logic [1:0] sel);
        case (sel)
            2'h0: return int'(WDS);
            2'h1: return int'(WDM);
            default: return int'(WDL);
        endcase
    endfunction

    task automatic print_verdict;
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(negedge core_clk) begin
        chk("reset_n", 1'(~reset_hi), reset_n);
    end

    // ========================================
    // main sequence
    initial begin
        seed = 32'h3d25;
        errors = 0;
        total_checks = 0;
        rst_b = 1'b0;
        supply_fail = 1'b0;
        trip_tolerance_select = 1'b0;
        manual_reset_n = 1'b1;
        watchdog_period_select = 2'h0;
        strobe_en = 1'b1;
        idle_level = 1'b1;
        interval = 8'h0a;
        cyc(20);
        chk("reset_hi power-up", 1, reset_hi);
        rst_b = 1'b1;
        wait_lvl("power-up hold", 1'b0, HOLD, HOLD + 3);
        for (int i = 0; i < 12; i++) begin
            interval = 8'(4 + {$random(seed)} % 25);
            case (i % 3)
                0: begin
                    trip_tolerance_select = 1'((i / 3) % 2);
                    supply_fail = 1'b1;
                    cyc(2);
                    chk("reset_hi supply", 1, reset_hi);
                    chk("tol", trip_tolerance_select,
                        tol_select_20pct);
                    cyc(1 + {$random(seed)} % 10);
                    supply_fail = 1'b0;
                    wait_lvl("supply hold", 1'b0, HOLD, HOLD + 3);
                end
                1: begin
                    w = 1 + {$random(seed)} % (DEB - 2);
                    manual_reset_n = 1'b0;
                    cyc(w);
                    manual_reset_n = 1'b1;
                    quiet("short press", DEB + 4);
                    manual_reset_n = 1'b0;
                    wait_lvl("press seen", 1'b1, 1, DEB + 6);
                    cyc({$random(seed)} % 8);
                    manual_reset_n = 1'b1;
                    wait_lvl("press hold", 1'b0, HOLD,
                             HOLD + DEB + 4);
                end
                default: begin
                    watchdog_period_select = 2'(i / 3);
                    lim = wd_limit(watchdog_period_select);
                    quiet("strobed quiet", 2 * lim);
                    idle_level = watchdog_period_select[0];
                    strobe_en = 1'b0;
                    wait_lvl("expiry", 1'b1, lim,
                             lim + 6);
                    strobe_en = 1'b1;
                    wait_lvl("wd hold", 1'b0, HOLD, HOLD + 3);
                end
            endcase
        end
        cyc(3);
        rst_b = 1'b0;
        cyc(2);
        chk("reset_hi re-reset", 1, reset_hi);
        rst_b = 1'b1;
        wait_lvl("re-reset hold", 1'b0, HOLD, HOLD + 3);
        print_verdict;
    end
endmodule
`default_nettype wire
